// *** wdt_top.sv ***
// Watchdog configuration, early warning interrupt, sync status and keyed service over APB
//
// Summary of operation
// - Upper config nibble picks closed-window length, 8 doubling to 16384 cycles.
// - Lower config nibble picks time-out length, 8 doubling to 16384 cycles.
// - In window mode the time-out field sets the open-window length.
// - Early-warning field sets cycles from period start to the warning.
// - Config and early-warning registers load from non-volatile settings at start-up.
// - Config writes only when disabled, synchronised; early-warning writes only when disabled, unsynchronised.
// - Writing one to enable-clear bit 0 disables the warning interrupt.
// - Writing one to enable-set bit 0 enables the warning interrupt.
// - Warning flag sets on warning event; writing one clears it.
// - Status bit 7 is high while a register synchronisation is running.
// - Writing key 0xa5 to the service register restarts the period, except in the closed window, where it resets the system.
// - Writing any other value to the service register resets the system.
// - In window mode the warning fires when the open window starts.
// - Interrupt is high while flag set and enabled.
// - Permanent lock makes control, config and early-warning registers read-only.
// - Synchronised access during busy stalls the bus, then completes.
`timescale 1ns/1ps
module wdt_top (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wdt_pkg::DATA_W-1:0] pwdata,
  output logic      [wdt_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       watchdog_count_clock,
  input  wire logic [7:0]                 nvm_ctrl,
  input  wire logic [7:0]                 nvm_config,
  input  wire logic [7:0]                 nvm_early_warn,
  output logic                            irq,
  output logic                            sys_reset
);
  import wdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]         ctrl_r;
  logic [7:0]         period_config_r;
  logic [3:0]         early_warn_delay_r;
  logic               irq_en_r;
  logic               flag_r;
  logic               load_done_r;
  logic               run_r;
  logic               win_act_r;
  logic [1:0]         sync_cnt_r;
  logic [2:0]         sync_what_r;
  logic [7:0]         sync_data_r;
  logic [15:0]        cnt_r;
  wd_state_type       st_r;
  logic [DATA_W-1:0]  prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic               irq_r;
  logic               sys_reset_r;
  logic               wd_tick;

  logic [15:0]        cnt_nxt;
  wd_state_type       st_nxt;
  logic               warn_evt;
  logic               tmo_evt;
  logic [15:0]        inc;

  tick_sync u_tick (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin     (watchdog_count_clock),
    .tick    (wd_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire [3:0] idx        = paddr[5:2];
  wire       in_range   = (paddr[ADDR_W-1:6] == '0) & (paddr[1:0] == 2'h0);
  wire       hit_ctrl   = in_range & (idx == IDX_CTRL);
  wire       hit_cfg    = in_range & (idx == IDX_CONFIG);
  wire       hit_warn   = in_range & (idx == IDX_EWCFG);
  wire       hit_clr    = in_range & (idx == IDX_ENCLR);
  wire       hit_set    = in_range & (idx == IDX_ENSET);
  wire       hit_flag   = in_range & (idx == IDX_FLAGS);
  wire       hit_stat   = in_range & (idx == IDX_STATUS);
  wire       hit_svc    = in_range & (idx == IDX_SERVICE);
  wire       mapped     = hit_ctrl | hit_cfg | hit_warn | hit_clr | hit_set | hit_flag |
                          hit_stat | hit_svc;

  wire       sync_busy  = |sync_what_r;
  wire       sync_done  = sync_busy & (sync_cnt_r == 2'h0);
  wire       acc        = psel & penable;
  wire       synced_wr  = pwrite & (hit_ctrl | hit_cfg | hit_svc);
  // Nothing answers before the start-up load so software never sees unloaded values
  wire       stall      = (synced_wr & sync_busy) | ~load_done_r;
  wire       pready_nxt = acc & ~pready_r & ~stall;
  wire       wr_fire    = acc & pready_r & pwrite & ~pslverr_r;
  wire [7:0] wdat       = pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Write effects

  wire       locked     = ctrl_r[CTRL_LOCK_BIT];
  wire       disabled   = ~ctrl_r[CTRL_EN_BIT] & ~run_r & ~locked;
  wire       ctrl_wr    = wr_fire & hit_ctrl & ~locked;
  wire       cfg_wr     = wr_fire & hit_cfg & disabled;
  wire       warn_wr    = wr_fire & hit_warn & disabled;
  wire       key_ok     = (wdat == SERVICE_KEY);
  wire       bad_key    = wr_fire & hit_svc & ~key_ok;
  wire       closed_svc = wr_fire & hit_svc & key_ok & (st_r == ST_CLOSED);
  wire       svc_wr     = wr_fire & hit_svc & key_ok & (st_r != ST_CLOSED);
  wire       sync_start = ctrl_wr | cfg_wr | svc_wr;
  wire       en_set     = wr_fire & hit_set & wdat[WARN_BIT];
  wire       en_clr     = wr_fire & hit_clr & wdat[WARN_BIT];
  wire       flag_clr   = wr_fire & hit_flag & wdat[WARN_BIT];
  wire       restart    = sync_done & sync_what_r[2];

  // Lock bit is sticky and also holds the watchdog running
  wire [7:0] ctrl_wval  = wdat | {locked, 7'h00};

  // Set wins over the clear when both land together
  wire       flag_nxt   = warn_evt | (flag_r & ~flag_clr);
  wire       en_nxt     = en_set | (irq_en_r & ~en_clr);

  //////////////////////////////////////////////////////////////////////////////
  // Period lengths

  wire [15:0] per_len   = len_of(period_config_r[PER_MSB:PER_LSB]);
  wire [15:0] win_len   = len_of(period_config_r[WIN_MSB:WIN_LSB]);
  wire [15:0] warn_len  = len_of(early_warn_delay_r);

  //////////////////////////////////////////////////////////////////////////////
  // Counter and window sequencing

  always_comb begin
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    warn_evt = 1'b0;
    tmo_evt = 1'b0;
    inc     = cnt_r + 16'h0001;
    if (!run_r) begin
      cnt_nxt = 16'h0000;
      st_nxt  = ST_OFF;
    end else if ((st_r == ST_OFF) || restart) begin
      cnt_nxt = 16'h0000;
      st_nxt  = win_act_r ? ST_CLOSED : ST_NORM;
    end else if (wd_tick) begin
      unique case (st_r)
        ST_NORM: begin
          // A warning later than the time-out never fires
          warn_evt = (inc == warn_len) & (warn_len < per_len);
          if (inc == per_len) begin
            tmo_evt = 1'b1;
            cnt_nxt = 16'h0000;
          end else begin
            cnt_nxt = inc;
          end
        end
        ST_CLOSED: begin
          if (inc == win_len) begin
            warn_evt = 1'b1;
            st_nxt  = ST_OPEN;
            cnt_nxt = 16'h0000;
          end else begin
            cnt_nxt = inc;
          end
        end
        ST_OPEN: begin
          if (inc == per_len) begin
            tmo_evt = 1'b1;
            st_nxt  = ST_CLOSED;
            cnt_nxt = 16'h0000;
          end else begin
            cnt_nxt = inc;
          end
        end
        ST_OFF: begin
          cnt_nxt = 16'h0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_done_r <= 1'b0;
      ctrl_r      <= REG_RST;
      period_config_r    <= REG_RST;
      early_warn_delay_r <= 4'h0;
    end else if (!load_done_r) begin
      load_done_r        <= 1'b1;
      ctrl_r             <= nvm_ctrl;
      period_config_r    <= nvm_config;
      early_warn_delay_r <= nvm_early_warn[3:0];
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= ctrl_wval;
      end
      if (sync_done && sync_what_r[1]) begin
        period_config_r <= sync_data_r;
      end
      if (warn_wr) begin
        early_warn_delay_r <= wdat[3:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_r     <= 1'b0;
      win_act_r <= 1'b0;
    end else if (!load_done_r) begin
      run_r     <= 1'b0;
      win_act_r <= 1'b0;
    end else if (sync_done && sync_what_r[0]) begin
      run_r     <= sync_data_r[CTRL_EN_BIT] | sync_data_r[CTRL_LOCK_BIT];
      win_act_r <= sync_data_r[CTRL_WEN_BIT];
    end else if (st_r == ST_OFF && ctrl_r[CTRL_EN_BIT] && !sync_busy) begin
      // Start-up load of an enabled watchdog needs no software write
      run_r     <= 1'b1;
      win_act_r <= ctrl_r[CTRL_WEN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_cnt_r  <= 2'h0;
      sync_what_r <= 3'h0;
      sync_data_r <= REG_RST;
    end else if (sync_start) begin
      sync_cnt_r  <= SYNC_CYCLES - 2'h1;
      sync_what_r <= {svc_wr, cfg_wr, ctrl_wr};
      sync_data_r <= ctrl_wr ? ctrl_wval : wdat;
    end else if (sync_done) begin
      sync_what_r <= 3'h0;
    end else if (sync_busy) begin
      sync_cnt_r  <= sync_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r       <= 16'h0000;
      st_r        <= ST_OFF;
      irq_en_r    <= IRQ_EN_RST;
      flag_r      <= FLAG_RST;
      irq_r       <= 1'b0;
      sys_reset_r <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      st_r        <= st_nxt;
      irq_en_r    <= en_nxt;
      flag_r      <= flag_nxt;
      irq_r       <= flag_nxt & en_nxt;
      sys_reset_r <= bad_key | closed_svc | tmo_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer

  wire [7:0] rd_val =
      hit_ctrl ? ctrl_r :
      hit_cfg  ? period_config_r :
      hit_warn ? {4'h0, early_warn_delay_r} :
      (hit_clr | hit_set) ? {7'h00, irq_en_r} :
      hit_flag ? {7'h00, flag_r} :
      hit_stat ? {sync_busy, 7'h00} :
      8'h00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pready_nxt & ~mapped;
      if (pready_nxt && !pwrite) begin
        prdata_r <= {24'h000000, rd_val};
      end
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign irq       = irq_r;
  assign sys_reset = sys_reset_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  irq_level_a: assert property (irq == (flag_r & irq_en_r))
    else $error("interrupt does not follow flag and enable");

  enable_set_a: assert property (en_set |=> irq_en_r ##1 (irq_en_r || $past(en_clr)))
    else $error("enable set write did not enable");

  enable_clr_a: assert property (en_clr |=> !irq_en_r)
    else $error("enable clear write did not disable");

  flag_clear_a: assert property (flag_clr && !warn_evt |=> !flag_r)
    else $error("flag not cleared by write of one");

  flag_set_a: assert property (warn_evt |=> flag_r)
    else $error("warning event lost");

  busy_span_a: assert property (sync_start |=> sync_busy [*3] ##1 !sync_busy)
    else $error("sync busy length wrong");

  bad_key_a: assert property (bad_key |=> sys_reset)
    else $error("wrong key did not reset");

  stall_bus_a: assert property (acc && synced_wr && sync_busy |=> !pready)
    else $error("synchronised access not stalled");

  lock_hold_a: assert property (wr_fire && hit_warn && locked |=> $stable(early_warn_delay_r))
    else $error("locked register changed");

  timeout_rst_a: assert property (tmo_evt |=> sys_reset)
    else $error("expiry did not reset");

  open_warn_a: assert property (st_r == ST_CLOSED && st_nxt == ST_OPEN |-> warn_evt)
    else $error("no warning at open window");

  closed_svc_a: assert property (closed_svc |=> sys_reset)
    else $error("closed window service did not reset");

  service_a: assert property (restart && run_r && st_r != ST_OFF |=> cnt_r == 16'h0000)
    else $error("service did not restart counter");

  cfg_apply_a: assert property (cfg_wr |=> ##3 period_config_r == $past(wdat, 4))
    else $error("config write not applied after sync");

endmodule

// *** wdt_pkg.sv ***
// Constants, register map and state codes for the watchdog configuration and service block
package wdt_pkg;

  localparam int         ADDR_W        = 12;
  localparam int         DATA_W        = 32;
  localparam int         REG_W         = 8;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL      = 4'h0;
  localparam logic [3:0] IDX_CONFIG    = 4'h1;
  localparam logic [3:0] IDX_EWCFG     = 4'h2;
  localparam logic [3:0] IDX_ENCLR     = 4'h4;
  localparam logic [3:0] IDX_ENSET     = 4'h5;
  localparam logic [3:0] IDX_FLAGS     = 4'h6;
  localparam logic [3:0] IDX_STATUS    = 4'h7;
  localparam logic [3:0] IDX_SERVICE   = 4'h8;

  // Field positions
  localparam int         CTRL_LOCK_BIT = 7;
  localparam int         CTRL_WEN_BIT  = 2;
  localparam int         CTRL_EN_BIT   = 1;
  localparam int         WIN_MSB       = 7;
  localparam int         WIN_LSB       = 4;
  localparam int         PER_MSB       = 3;
  localparam int         PER_LSB       = 0;
  localparam int         WARN_BIT      = 0;
  localparam int         SYNC_BIT      = 7;

  // Reset values
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic       IRQ_EN_RST    = 1'b0;
  localparam logic       FLAG_RST      = 1'b0;

  // Service key and period coding
  localparam logic [7:0]  SERVICE_KEY  = 8'ha5;
  localparam logic [3:0]  CODE_MAX     = 4'hb;
  localparam logic [15:0] BASE_LEN     = 16'h0008;

  // Bus-clock cycles a synchronised write stays busy
  localparam logic [1:0]  SYNC_CYCLES  = 2'h3;

  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_NORM   = 4'b0010,
    ST_CLOSED = 4'b0100,
    ST_OPEN   = 4'b1000
  } wd_state_type;

  // Reserved codes clamp to the longest length rather than wrapping
  function automatic logic [15:0] len_of(input logic [3:0] code);
    logic [3:0] sel;
    sel = (code > CODE_MAX) ? CODE_MAX : code;
    return BASE_LEN << sel;
  endfunction

endpackage

// *** tick_sync.sv ***
// Three-stage synchroniser turning the watchdog count clock pin into one-cycle ticks
`timescale 1ns/1ps
module tick_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      tick
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic tick_r;

  // A change is accepted only once the second and third stages agree
  wire  agree   = (s2_r == s3_r);
  wire  rise    = agree & s3_r & ~lvl_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      lvl_r  <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      s1_r   <= pin;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      tick_r <= rise;
      if (agree) begin
        lvl_r <= s3_r;
      end
    end
  end

  assign tick = tick_r;
endmodule

// *** wdt_top_tb_top.sv ***
// Self-checking testbench for the watchdog configuration and service block
`timescale 1ns/1ps
module wdt_top_tb_top;
  import wdt_pkg::*;

  logic                mclk;
  logic                reset_n;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                watchdog_count_clock;
  logic [7:0]          nvm_ctrl;
  logic [7:0]          nvm_config;
  logic [7:0]          nvm_early_warn;
  logic                irq;
  logic                sys_reset;
  int                  miscompares;
  int                  n_tests;
  int                  n_resets;
  int                  cycles;
  int                  base;

  wdt_top u_wdt_top (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .watchdog_count_clock (watchdog_count_clock),
    .nvm_ctrl             (nvm_ctrl),
    .nvm_config           (nvm_config),
    .nvm_early_warn       (nvm_early_warn),
    .irq                  (irq),
    .sys_reset            (sys_reset)
  );

  always #50 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reset pulses are counted so expectations are differences, not absolute times
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (sys_reset === 1'b1) begin
      n_resets <= n_resets + 1;
    end
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high; released only at that edge
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {6'h00, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    check(r, {24'h000000, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Each tick is held long enough to pass the three-flop synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      watchdog_count_clock <= 1'b1;
      idle(3);
      watchdog_count_clock <= 1'b0;
      idle(3);
    end
    idle(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdchk(IDX_CONFIG, 8'h21);
    rdchk(IDX_EWCFG, 8'h01);
    rdchk(IDX_ENCLR, 8'h00);
    rdchk(IDX_ENSET, 8'h00);
    rdchk(IDX_FLAGS, 8'h00);
    rdchk(IDX_STATUS, 8'h00);
    apb(1'b0, 4'h3, 8'h00, r, e);
    check({31'h0, e}, 32'h1);
  endtask

  task automatic t_irq_en();
    wr(IDX_ENSET, 8'h01);
    rdchk(IDX_ENCLR, 8'h01);
    wr(IDX_ENSET, 8'h00);
    rdchk(IDX_ENSET, 8'h01);
    wr(IDX_ENCLR, 8'h00);
    rdchk(IDX_ENCLR, 8'h01);
    wr(IDX_ENCLR, 8'h01);
    rdchk(IDX_ENSET, 8'h00);
  endtask

  // Second write lands while the first is still synchronising
  task automatic t_sync();
    wr(IDX_CONFIG, 8'h15);
    wr(IDX_CONFIG, 8'h12);
    rdchk(IDX_STATUS, 8'h80);
    idle(8);
    rdchk(IDX_STATUS, 8'h00);
    rdchk(IDX_CONFIG, 8'h12);
  endtask

  task automatic t_normal();
    wr(IDX_ENSET, 8'h01);
    wr(IDX_CTRL, 8'h02);
    idle(10);
    base = n_resets;
    ticks(15);
    check({31'h0, irq}, 32'h0);
    ticks(1);
    check({31'h0, irq}, 32'h1);
    rdchk(IDX_FLAGS, 8'h01);
    wr(IDX_EWCFG, 8'h03);
    rdchk(IDX_EWCFG, 8'h01);
    ticks(15);
    check(n_resets, base);
    ticks(1);
    check(n_resets, base + 1);
    wr(IDX_FLAGS, 8'h00);
    rdchk(IDX_FLAGS, 8'h01);
    wr(IDX_FLAGS, 8'h01);
    idle(2);
    check({31'h0, irq}, 32'h0);
    ticks(20);
    wr(IDX_SERVICE, SERVICE_KEY);
    idle(6);
    ticks(31);
    check(n_resets, base + 1);
    ticks(1);
    check(n_resets, base + 2);
    wr(IDX_SERVICE, 8'h5a);
    idle(3);
    check(n_resets, base + 3);
  endtask

  // Closed 16 ticks, open 16 ticks; offset code 0 must be ignored here
  // A closed-window service only resets; the closed window keeps counting
  task automatic t_window();
    wr(IDX_CTRL, 8'h00);
    idle(6);
    wr(IDX_CONFIG, 8'h11);
    wr(IDX_EWCFG, 8'h00);
    wr(IDX_FLAGS, 8'h01);
    wr(IDX_CTRL, 8'h06);
    idle(10);
    base = n_resets;
    ticks(4);
    wr(IDX_SERVICE, SERVICE_KEY);
    idle(3);
    check(n_resets, base + 1);
    ticks(11);
    rdchk(IDX_FLAGS, 8'h00);
    ticks(1);
    rdchk(IDX_FLAGS, 8'h01);
    wr(IDX_SERVICE, SERVICE_KEY);
    idle(6);
    check(n_resets, base + 1);
    ticks(31);
    check(n_resets, base + 1);
    ticks(1);
    check(n_resets, base + 2);
  endtask

  task automatic t_lock();
    wr(IDX_CTRL, 8'h80);
    idle(6);
    wr(IDX_CTRL, 8'h00);
    idle(6);
    rdchk(IDX_CTRL, 8'h80);
    wr(IDX_CONFIG, 8'h33);
    idle(6);
    rdchk(IDX_CONFIG, 8'h11);
    wr(IDX_EWCFG, 8'h05);
    rdchk(IDX_EWCFG, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    watchdog_count_clock = 1'b0;
    nvm_ctrl = 8'h00;
    nvm_config = 8'h21;
    nvm_early_warn = 8'h01;
    miscompares = 0;
    n_tests = 0;
    n_resets = 0;
    cycles = 0;
    idle(10);
    reset_n <= 1'b1;
    idle(3);
    t_reset();
    t_irq_en();
    t_sync();
    t_normal();
    t_window();
    t_lock();
    summarize();
  end
endmodule
